/* hw/tcd_pkg.sv */
/*
 * shared constants for the compare channel d and fault block: register
 * indices, bit positions, reset values, mode codes and filter length.
 * assumes a 32-bit classic wishbone slave; byte address = 4 * index.
 */
package tcd_pkg;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_FAULT_CTRL = 8'h26;
	localparam logic [7:0] IDX_CMP_CTRL   = 8'h20;
	localparam logic [7:0] IDX_CMP_VALUE  = 8'h21;
	localparam logic [7:0] IDX_TOP_VALUE  = 8'h22;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h23;
	localparam logic [7:0] IDX_IRQ_MASK   = 8'h24;

	// timer_fault_waveform_control fields
	localparam int FC_IRQ_EN  = 7;
	localparam int FC_MODE_EN = 6;
	localparam int FC_FILTER  = 5;
	localparam int FC_EDGE    = 4;
	localparam int FC_FLAG    = 2;
	localparam int FC_WGM_LSB = 0;

	// compare control fields
	localparam int CC_MODE_LSB = 6;
	localparam int CC_FORCE    = 1;
	localparam int CC_PWM      = 0;

	// interrupt status and mask bits
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_MATCH = 1;
	localparam int IRQ_W     = 2;

	// reset values
	localparam logic [7:0]  FAULT_CTRL_RST = 8'h00;
	localparam logic [15:0] TOP_RST        = 16'h03ff;
	localparam logic [15:0] CMP_RST        = 16'h0000;

	// waveform generation code for phase and frequency correct pwm
	localparam logic [1:0] WGM_PFC = 2'h1;

	// samples the noise filter needs before its output moves
	localparam int FILTER_SAMPLES = 4;

	// compare output modes, encoded 00, 01, 10, 11 in this order
	typedef enum logic [1:0] {
		COM_OFF,
		COM_BOTH,
		COM_TRUE_CLR,
		COM_TRUE_SET
	} tcd_com_e;

endpackage

/* hw/tcd_cmp_if.sv */
/*
 * carrier between the timer core and the compare output stage.
 * assumes one clock domain; all signals but pwm_pfc come from flip-flops of the core, pwm_pfc is decoded from them.
 */
`timescale 1ns/10ps
interface tcd_cmp_if;
	tcd_pkg::tcd_com_e mode;      // compare output mode
	logic              pwm_pfc;   // phase and frequency correct pwm active
	logic              match;     // real compare match, one cycle
	logic              count_up;  // counter direction at the match
	logic              force_p;   // forced compare, one cycle

	modport ctrl (output mode, output pwm_pfc, output match, output count_up, output force_p);
	modport outp (input mode, input pwm_pfc, input match, input count_up, input force_p);
endinterface

/* hw/tcd_cmp_out.sv */
/*
 * compare output stage: waveform register and the true and complementary
 * pin drivers. assumes match and force pulses arrive from the timer core.
 */
`timescale 1ns/10ps
module tcd_cmp_out (
	input  wire logic clock_i,     // system clock
	input  wire logic reset_n_i,   // async reset, active low
	tcd_cmp_if.outp   cmp,         // events and mode from the core
	output logic      pin_o,       // true pin value
	output logic      pin_oe_o,    // true pin driven
	output logic      comp_o,      // complementary pin value
	output logic      comp_oe_o    // complementary pin driven
);
	typedef struct packed {
		logic wave;
		logic pin;
		logic pin_oe;
		logic comp;
		logic comp_oe;
	} tcd_out_s;

	tcd_out_s s;       // registered state
	tcd_out_s next_s;  // next state

	// waveform update and pin mapping
	always_comb
	begin
		next_s = s;
		if (cmp.match || cmp.force_p)
		begin
			if (cmp.pwm_pfc)
			begin
				unique case (cmp.mode)
					tcd_pkg::COM_BOTH,
					tcd_pkg::COM_TRUE_CLR: next_s.wave = !cmp.count_up;
					tcd_pkg::COM_TRUE_SET: next_s.wave = cmp.count_up;
					tcd_pkg::COM_OFF:      next_s.wave = s.wave;
				endcase
			end
			else
			begin
				// non-pwm: toggle, clear or set
				unique case (cmp.mode)
					tcd_pkg::COM_BOTH:     next_s.wave = !s.wave;
					tcd_pkg::COM_TRUE_CLR: next_s.wave = 1'b0;
					tcd_pkg::COM_TRUE_SET: next_s.wave = 1'b1;
					tcd_pkg::COM_OFF:      next_s.wave = s.wave;
				endcase
			end
		end
		// pins follow on the next edge
		next_s.pin     = next_s.wave;
		next_s.pin_oe  = (cmp.mode != tcd_pkg::COM_OFF);
		next_s.comp    = !next_s.wave;
		next_s.comp_oe = (cmp.mode == tcd_pkg::COM_BOTH) && cmp.pwm_pfc;
	end

	// state register
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign pin_o     = s.pin;
	assign pin_oe_o  = s.pin_oe;
	assign comp_o    = s.comp;
	assign comp_oe_o = s.comp_oe;

	chk_pfc_up_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(cmp.match && cmp.pwm_pfc && cmp.count_up && (cmp.mode == tcd_pkg::COM_BOTH))
		|=> (!pin_o && pin_oe_o && comp_o && comp_oe_o))
		else $error("mode 01 up match did not clear the pair");
	chk_pfc_up_set: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(cmp.match && cmp.pwm_pfc && (cmp.mode == tcd_pkg::COM_TRUE_SET))
		|=> ((pin_o == $past(cmp.count_up)) && !comp_oe_o))
		else $error("mode 11 match gave wrong level");
	chk_mode_off_pins: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(cmp.mode == tcd_pkg::COM_OFF) |=> (!pin_oe_o && !comp_oe_o))
		else $error("pins driven in mode 00");
	// a forced clear in non-pwm must leave the true pin driven low
	chk_force_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(cmp.force_p && !cmp.pwm_pfc && (cmp.mode == tcd_pkg::COM_TRUE_CLR))
		|=> (pin_oe_o && !pin_o))
		else $error("forced clear left the pin high");
endmodule // tcd_cmp_out

/* hw/tcd_fault_filter.sv */
/*
 * fault input path: optional four-sample noise filter and edge select,
 * giving a one-cycle fault event. assumes the pin is synchronous.
 */
`timescale 1ns/10ps
module tcd_fault_filter (
	input  wire logic clock_i,      // system clock
	input  wire logic reset_n_i,    // async reset, active low
	input  wire logic pin_i,        // fault input pin
	input  wire logic filter_en_i,  // noise filter on
	input  wire logic edge_rise_i,  // 1 rising, 0 falling
	input  wire logic mode_en_i,    // fault mode active
	output logic      event_o       // fault event, one cycle
);
	typedef struct packed {
		logic [tcd_pkg::FILTER_SAMPLES-1:0] hist;  // last samples
		logic                               filt;  // filtered level
		logic                               prev;  // filt one cycle ago
		logic                               evt;   // event pulse
	} tcd_flt_s;

	tcd_flt_s s;       // registered state
	tcd_flt_s next_s;  // next state

	// sampling, filter and edge detect
	always_comb
	begin
		next_s = s;
		next_s.hist = {s.hist[tcd_pkg::FILTER_SAMPLES-2:0], pin_i};
		// move only after four equal samples
		if (filter_en_i)
		begin
			if ((&s.hist) || !(|s.hist))
				next_s.filt = s.hist[0];
		end
		else
			next_s.filt = pin_i;
		next_s.prev = s.filt;
		next_s.evt = mode_en_i && (s.filt != s.prev) && (s.filt == edge_rise_i);
	end

	// state register; idle level low, so filt starts low
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign event_o = s.evt;

	chk_filter_stable: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		($past(filter_en_i) && (s.filt != $past(s.filt)))
		|-> (($past(pin_i, 2) == s.filt) && ($past(pin_i, 5) == s.filt)))
		else $error("filter moved before four equal samples");
	chk_edge_select: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		s.evt |-> (($past(s.filt) == $past(edge_rise_i)) && $past(s.filt != s.prev)))
		else $error("fault event on the wrong edge");
	chk_mode_gate: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		s.evt |-> $past(mode_en_i))
		else $error("fault event while fault mode off");
endmodule // tcd_fault_filter

/* hw/tcd_top.sv */
/*
 * timer compare channel d with fault protection input, reached over a
 * classic wishbone slave with 32-bit data. holds the up or up/down
 * counter, the register file, the interrupt status and mask, and drives
 * the true and complementary compare pins.
 * assumes one 125 MHz clock and a fault pin synchronous to it.
 */
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
// Behaviour
// - modes 01/10: clear up, set down
// - mode 11: set up, clear down
// - force ignored while pwm enabled
// - force acts as a real match
// - force uses mode written alongside
// - force raises no interrupt
// - force bit always reads zero
// - pwm enable compares against compare value
// - fault interrupt only with enable bit
// - fault mode enable qualifies fault edges
// - filter needs four equal samples
// - edge select: 0 falling, 1 rising
// - pfc behaviour needs pwm and mode field
module tcd_top #(
	parameter int CNT_W = 10  // counter and compare width
) (
	input  wire logic        clock_i,              // 125 MHz system clock
	input  wire logic        reset_n_i,            // async reset, active low
	input  wire logic        wb_cyc_i,             // wishbone cycle
	input  wire logic        wb_stb_i,             // wishbone strobe
	input  wire logic        wb_we_i,              // wishbone write
	input  wire logic [9:0]  wb_adr_i,             // byte address
	input  wire logic [3:0]  wb_sel_i,             // byte lanes
	input  wire logic [31:0] wb_dat_i,             // write data
	output logic      [31:0] wb_dat_o,             // read data
	output logic             wb_ack_o,             // acknowledge
	input  wire logic        fault_input_pin_i,    // fault pin
	output logic             compare_d_pin_o,      // true pin value
	output logic             compare_d_pin_oe_o,   // true pin driven
	output logic             compare_d_comp_o,     // complementary value
	output logic             compare_d_comp_oe_o,  // complementary driven
	output logic             irq_o                 // level interrupt
);
	typedef struct packed {
		logic                          ack;          // bus answer
		logic [31:0]                   dat;          // read data
		logic [7:0]                    fault_ctrl;   // fault and wgm control
		tcd_pkg::tcd_com_e             mode;         // compare output mode
		logic                          pwm_en;       // pwm_d_enable
		logic [CNT_W-1:0]              cmp_val;      // compare_d_value
		logic [CNT_W-1:0]              top_val;      // counter top
		logic [CNT_W-1:0]              cnt;          // timer counter
		logic                          down;         // counting down
		logic                          match;        // match pulse
		logic                          up;           // direction at match
		logic                          force_p;      // force pulse
		logic [tcd_pkg::IRQ_W-1:0]     irq_status;   // sticky events
		logic [tcd_pkg::IRQ_W-1:0]     irq_mask;     // interrupt mask
		logic                          irq;          // interrupt level
	} tcd_top_s;

	tcd_top_s    s;          // registered state
	tcd_top_s    next_s;     // next state
	logic [7:0]  idx;        // register index
	logic        req;        // new bus request
	logic        pfc;        // pfc pwm active
	logic        fault_evt;  // event from the fault path
	logic [31:0] rdata;      // read mux
	logic [7:0]  wr8;        // low byte written

	tcd_cmp_if cmp_bus ();   // to the compare output stage

	// merge written byte lanes into a 16-bit register image
	function automatic logic [15:0] tcd_merge16(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0])
			res[7:0] = dat[7:0];
		if (sel[1])
			res[15:8] = dat[15:8];
		return res;
	endfunction

	assign idx = wb_adr_i[9:2];
	// ack is high for one cycle, so a held request is taken once
	assign req = wb_cyc_i && wb_stb_i && !s.ack;
	assign wr8 = wb_dat_i[7:0];
	// pfc only with pwm and mode field
	assign pfc = s.pwm_en
		&& (s.fault_ctrl[tcd_pkg::FC_WGM_LSB+:2] == tcd_pkg::WGM_PFC);

	// read mux, unmapped indices read zero
	always_comb
	begin
		rdata = '0;
		unique case (idx)
			tcd_pkg::IDX_FAULT_CTRL: rdata[7:0] = s.fault_ctrl;
			tcd_pkg::IDX_CMP_CTRL:   rdata[7:0] = {s.mode, 5'h00, s.pwm_en};
			tcd_pkg::IDX_CMP_VALUE:  rdata[CNT_W-1:0] = s.cmp_val;
			tcd_pkg::IDX_TOP_VALUE:  rdata[CNT_W-1:0] = s.top_val;
			tcd_pkg::IDX_IRQ_STATUS: rdata[tcd_pkg::IRQ_W-1:0] = s.irq_status;
			tcd_pkg::IDX_IRQ_MASK:   rdata[tcd_pkg::IRQ_W-1:0] = s.irq_mask;
			default:                 rdata = '0;
		endcase
	end

	// counter, bus access, events and interrupt
	always_comb
	begin
		next_s = s;
		next_s.force_p = 1'b0;
		// counter: up/down in pfc, plain up count otherwise
		if (pfc)
		begin
			if (!s.down)
			begin
				next_s.down = (s.cnt == s.top_val);
				next_s.cnt  = next_s.down ? s.cnt - CNT_W'(1) : s.cnt + CNT_W'(1);
			end
			else
			begin
				next_s.down = (s.cnt != '0);
				next_s.cnt  = next_s.down ? s.cnt - CNT_W'(1) : s.cnt + CNT_W'(1);
			end
		end
		else
		begin
			next_s.down = 1'b0;
			next_s.cnt  = (s.cnt == s.top_val) ? '0 : s.cnt + CNT_W'(1);
		end
		next_s.match = (s.cnt == s.cmp_val);
		next_s.up    = !s.down;
		// bus slave, one cycle to ack
		next_s.ack = req;
		if (req && !wb_we_i)
		begin
			next_s.dat = rdata;
			// read of the status register clears it
			if (idx == tcd_pkg::IDX_IRQ_STATUS)
				next_s.irq_status = '0;
		end
		if (req && wb_we_i)
		begin
			unique case (idx)
				tcd_pkg::IDX_FAULT_CTRL:
				begin
					if (wb_sel_i[0])
					begin
						next_s.fault_ctrl = wr8;
						// flag clears on writing one, else holds
						next_s.fault_ctrl[tcd_pkg::FC_FLAG] =
							s.fault_ctrl[tcd_pkg::FC_FLAG] && !wr8[tcd_pkg::FC_FLAG];
					end
				end
				tcd_pkg::IDX_CMP_CTRL:
				begin
					if (wb_sel_i[0])
					begin
						next_s.mode   = tcd_pkg::tcd_com_e'(wr8[tcd_pkg::CC_MODE_LSB+:2]);
						next_s.pwm_en = wr8[tcd_pkg::CC_PWM];
						// new mode latched with the force
						next_s.force_p = wr8[tcd_pkg::CC_FORCE] && !wr8[tcd_pkg::CC_PWM];
					end
				end
				tcd_pkg::IDX_CMP_VALUE:
					next_s.cmp_val = CNT_W'(tcd_merge16(16'(s.cmp_val), wb_dat_i, wb_sel_i));
				tcd_pkg::IDX_TOP_VALUE:
					next_s.top_val = CNT_W'(tcd_merge16(16'(s.top_val), wb_dat_i, wb_sel_i));
				tcd_pkg::IDX_IRQ_MASK:
				begin
					if (wb_sel_i[0])
						next_s.irq_mask = wr8[tcd_pkg::IRQ_W-1:0];
				end
				default:
					next_s.dat = s.dat;
			endcase
		end
		// fault event sets the flag, set wins
		if (fault_evt)
		begin
			next_s.fault_ctrl[tcd_pkg::FC_FLAG] = 1'b1;
			if (s.fault_ctrl[tcd_pkg::FC_IRQ_EN])
				next_s.irq_status[tcd_pkg::IRQ_FAULT] = 1'b1;
		end
		if (s.match)
			next_s.irq_status[tcd_pkg::IRQ_MATCH] = 1'b1;
		next_s.irq = |(next_s.irq_status & next_s.irq_mask);
	end

	// state register
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s            <= '0;
			s.fault_ctrl <= tcd_pkg::FAULT_CTRL_RST;
			s.top_val    <= CNT_W'(tcd_pkg::TOP_RST);
			s.cmp_val    <= CNT_W'(tcd_pkg::CMP_RST);
		end
		else
			s <= next_s;
	end

	// events and mode to the output stage
	assign cmp_bus.mode     = s.mode;
	assign cmp_bus.pwm_pfc  = pfc;
	assign cmp_bus.match    = s.match;
	assign cmp_bus.count_up = s.up;
	assign cmp_bus.force_p  = s.force_p;

	// fault input path
	tcd_fault_filter u_fault (
		.clock_i     (clock_i),
		.reset_n_i   (reset_n_i),
		.pin_i       (fault_input_pin_i),
		.filter_en_i (s.fault_ctrl[tcd_pkg::FC_FILTER]),
		.edge_rise_i (s.fault_ctrl[tcd_pkg::FC_EDGE]),
		.mode_en_i   (s.fault_ctrl[tcd_pkg::FC_MODE_EN]),
		.event_o     (fault_evt)
	);

	// compare pins
	tcd_cmp_out u_out (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.cmp       (cmp_bus.outp),
		.pin_o     (compare_d_pin_o),
		.pin_oe_o  (compare_d_pin_oe_o),
		.comp_o    (compare_d_comp_o),
		.comp_oe_o (compare_d_comp_oe_o)
	);

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign irq_o    = s.irq;

	chk_force_reads_zero: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(wb_ack_o && ($past(idx) == tcd_pkg::IDX_CMP_CTRL) && !$past(wb_we_i))
		|-> !wb_dat_o[tcd_pkg::CC_FORCE])
		else $error("force bit read back as one");
	chk_force_gated: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		s.force_p |-> !s.pwm_en)
		else $error("force accepted in pwm mode");
	chk_force_no_irq: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		$rose(s.irq_status[tcd_pkg::IRQ_MATCH]) |-> $past(s.match))
		else $error("match status set without a real match");
	chk_fault_irq_gate: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		$rose(s.irq_status[tcd_pkg::IRQ_FAULT])
		|-> $past(s.fault_ctrl[tcd_pkg::FC_IRQ_EN]) && $past(fault_evt))
		else $error("fault status set while interrupt disabled");
	chk_fault_flag_set: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		fault_evt |=> s.fault_ctrl[tcd_pkg::FC_FLAG])
		else $error("fault event did not set the flag");
	chk_irq_level: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(irq_o == |(s.irq_status & s.irq_mask)))
		else $error("interrupt level disagrees with status and mask");
	// the forced action must carry the mode written in the same access
	chk_force_new_mode: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		s.force_p |-> (s.mode == tcd_pkg::tcd_com_e'($past(wr8[tcd_pkg::CC_MODE_LSB+:2]))))
		else $error("force used a stale output mode");
endmodule // tcd_top

/* verif/tcd_stage_model.sv */
/*
 * far-side model: power stage gate inputs behind the compare pins and the
 * source of the fault signal. assumes one system clock for everything.
 */
`timescale 1ns/10ps
module tcd_stage_model (
	input  wire logic clock_i,    // system clock
	input  wire logic pin_i,      // true pin value
	input  wire logic pin_oe_i,   // true pin driven
	input  wire logic comp_i,     // complementary value
	input  wire logic comp_oe_i,  // complementary driven
	output logic      gate_hi_o,  // level at the high-side gate
	output logic      gate_lo_o,  // level at the low-side gate
	output logic      fault_o     // fault signal into the block
);
	// gate inputs carry pull-downs, so an undriven pin reads low
	assign gate_hi_o = pin_oe_i ? pin_i : 1'b0;
	assign gate_lo_o = comp_oe_i ? comp_i : 1'b0;

	// fault line idles low, matching the block's filter reset level
	initial fault_o = 1'b0;

	// level moves just after a rising edge, never on it
	task automatic set_fault(input logic lvl);
		@(posedge clock_i);
		fault_o <= lvl;
	endtask
endmodule // tcd_stage_model

/* verif/tb.sv */
/*
 * self-checking bench for tcd_top: forced and pwm compare actions, fault
 * path with filter and edge select, over wishbone register tasks.
 * assumes tcd_pkg, the design files and tcd_stage_model are compiled.
 */
`timescale 1ns/10ps
module tb;
	localparam int TOP_PFC = 16;       // short pfc period keeps windows small
	logic        clock_i;              // system clock
	logic        reset_n_i;            // reset, active low
	logic        wb_cyc;               // bus cycle
	logic        wb_stb;               // bus strobe
	logic        wb_we;                // bus write
	logic [9:0]  wb_adr;               // byte address
	logic [3:0]  wb_sel;               // byte lanes
	logic [31:0] wb_wdat;              // write data
	logic [31:0] wb_rdat;              // read data
	logic        wb_ack;               // acknowledge
	logic        fault_pin;            // fault line from the model
	logic        pin;                  // true pin value
	logic        pin_oe;               // true pin enable
	logic        comp;                 // complementary value
	logic        comp_oe;              // complementary enable
	logic        irq;                  // interrupt level
	logic        gate_hi;              // resolved true pin
	logic        gate_lo;              // resolved complementary pin
	logic [63:0] exp_q[$];             // expected read data and mask
	logic [63:0] note;                 // oldest note
	logic [31:0] rnd;                  // xorshift state
	logic [3:0]  lanes;                // byte lanes of the next request
	int          cval;                 // compare value in pfc test
	int          hi_cnt;               // high cycles in a window
	int          mismatches;           // failed comparisons
	int          samples_checked;      // all comparisons
	// forced modes and the pin level each must leave
	logic [1:0]  fmode[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
	logic        fpin[4]  = '{1'b1, 1'b0, 1'b1, 1'b0};
	// fault cases: control, irq after rise, flag after rise, after fall
	logic [10:0] ftab[4]  = '{{8'hd0, 3'b110}, {8'hc0, 3'b001},
		{8'h50, 3'b010}, {8'h90, 3'b000}};

	tcd_top #(
		.CNT_W(10)
	) dut_u (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb),
		.wb_we_i(wb_we),
		.wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack),
		.fault_input_pin_i(fault_pin),
		.compare_d_pin_o(pin),
		.compare_d_pin_oe_o(pin_oe),
		.compare_d_comp_o(comp),
		.compare_d_comp_oe_o(comp_oe),
		.irq_o(irq)
	);

	tcd_stage_model stage_u (
		.clock_i(clock_i),
		.pin_i(pin),
		.pin_oe_i(pin_oe),
		.comp_i(comp),
		.comp_oe_i(comp_oe),
		.gate_hi_o(gate_hi),
		.gate_lo_o(gate_lo),
		.fault_o(fault_pin)
	);

	// 125 MHz clock
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic cmp_bit(input string what, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// one classic cycle; request held until ack is sampled high, only the
	// watchdog ends a wait that never sees ack
	task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clock_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		// low address bits are ignored by the slave, so they get noise
		wb_adr <= {idx, rnd[1:0]};
		rnd = xs(rnd);
		wb_sel <= lanes;
		wb_wdat <= d;
		do
		begin
			@(posedge clock_i);
		end
		while (wb_ack !== 1'b1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d);
	endtask

	// the note is taken by the monitor at the ack edge
	task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back({e & m, m});
		xfer(1'b0, idx, 32'h0000_0000);
	endtask

	// clear flag and status, then the level interrupt must drop
	task automatic clear_fault(input logic [7:0] ctl);
		wr(tcd_pkg::IDX_FAULT_CTRL, {24'h00_0000, ctl | 8'h04});
		rd(tcd_pkg::IDX_IRQ_STATUS, 32'h0000_0000, 32'h0000_0000);
		wait_cyc(2);
		cmp_bit("irq after clear", 1'b0, irq);
	endtask

	// read results are compared against the oldest note
	always @(posedge clock_i)
	begin
		if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
		begin
			note = exp_q.pop_front();
			cmp_word("read data", note[63:32], wb_rdat & note[31:0]);
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog: the whole run needs far fewer cycles than this
	initial
	begin
		#(8 * 40000);
		mismatches++;
		$display("watchdog expired");
		stop_test();
	end

	initial
	begin
		{wb_cyc, wb_stb, wb_we} = 3'b000;
		wb_adr = 10'h000;
		wb_sel = 4'hf;
		lanes = 4'hf;
		wb_wdat = 32'h0000_0000;
		reset_n_i = 1'b0;
		rnd = 32'h0000_0060;
		repeat (6) @(posedge clock_i);
		reset_n_i <= 1'b1;
		rd(tcd_pkg::IDX_FAULT_CTRL, 32'h0000_0000, 32'h0000_00ff);
		rd(tcd_pkg::IDX_TOP_VALUE, 32'h0000_03ff, 32'h0000_ffff);
		rd(8'h30, 32'h0000_0000, 32'hffff_ffff);
		// only lane 1 written: the low byte of the compare value holds
		lanes = 4'h2;
		wr(tcd_pkg::IDX_CMP_VALUE, 32'h0000_0155);
		lanes = 4'hf;
		rd(tcd_pkg::IDX_CMP_VALUE, 32'h0000_0100, 32'h0000_ffff);
		$display("reset values done");
		// compare value above top: no real match can happen
		wr(tcd_pkg::IDX_TOP_VALUE, 32'h0000_0100);
		wr(tcd_pkg::IDX_CMP_VALUE, 32'h0000_0200);
		// counter and compare value both start at zero, so a real match
		// right after reset has left the match status set
		rd(tcd_pkg::IDX_IRQ_STATUS, 32'h0000_0002, 32'h0000_0003);
		wr(tcd_pkg::IDX_IRQ_MASK, 32'h0000_0003);
		for (int i = 0; i < 4; i++)
		begin
			wr(tcd_pkg::IDX_CMP_CTRL, {24'h00_0000, fmode[i], 6'h02});
			wait_cyc(3);
			cmp_bit("forced pin", fpin[i], gate_hi);
			cmp_bit("true enable", 1'b1, pin_oe);
		end
		rd(tcd_pkg::IDX_CMP_CTRL, 32'h0000_0040, 32'h0000_00ff);
		wr(tcd_pkg::IDX_CMP_CTRL, 32'h0000_00c3);
		wait_cyc(3);
		cmp_bit("pin with pwm on", 1'b0, gate_hi);
		rd(tcd_pkg::IDX_CMP_CTRL, 32'h0000_00c1, 32'h0000_00ff);
		rd(tcd_pkg::IDX_IRQ_STATUS, 32'h0000_0000, 32'h0000_0003);
		cmp_bit("irq after force", 1'b0, irq);
		$display("force test done");
		wr(tcd_pkg::IDX_FAULT_CTRL, {30'h0, tcd_pkg::WGM_PFC});
		wr(tcd_pkg::IDX_TOP_VALUE, 32'(TOP_PFC));
		// counter may sit above the new top and must run through its wrap
		wait_cyc(1100);
		for (int m = 1; m < 4; m++)
		begin
			rnd = xs(rnd);
			cval = 1 + int'(rnd % 32'(TOP_PFC - 1));
			wr(tcd_pkg::IDX_CMP_VALUE, 32'(cval));
			wr(tcd_pkg::IDX_CMP_CTRL, 32'((m << 6) | 1));
			wait_cyc(4 * TOP_PFC);
			hi_cnt = 0;
			repeat (2 * TOP_PFC)
			begin
				@(posedge clock_i);
				#1;
				hi_cnt += int'(gate_hi);
			end
			cmp_word("high cycles", 32'((m == 3) ? 2 * (TOP_PFC - cval) : 2 * cval), 32'(hi_cnt));
			cmp_bit("comp enable", m == 1, comp_oe);
			cmp_bit("comp level", (m == 1) ? ~gate_hi : 1'b0, gate_lo);
		end
		wr(tcd_pkg::IDX_CMP_CTRL, 32'h0000_0001);
		wait_cyc(3);
		cmp_bit("true enable off", 1'b0, pin_oe);
		cmp_bit("comp enable off", 1'b0, comp_oe);
		wr(tcd_pkg::IDX_CMP_CTRL, 32'h0000_0000);
		wr(tcd_pkg::IDX_CMP_VALUE, 32'h0000_0200);
		wr(tcd_pkg::IDX_TOP_VALUE, 32'h0000_0100);
		wr(tcd_pkg::IDX_IRQ_MASK, 32'h0000_0001);
		clear_fault(8'h00);
		$display("pwm test done");
		for (int i = 0; i < 4; i++)
		begin
			wr(tcd_pkg::IDX_FAULT_CTRL, {24'h00_0000, ftab[i][10:3]});
			stage_u.set_fault(1'b1);
			wait_cyc(8);
			cmp_bit("fault irq", ftab[i][2], irq);
			rd(tcd_pkg::IDX_FAULT_CTRL, 32'({ftab[i][1], 2'b00}), 32'h0000_0004);
			clear_fault(ftab[i][10:3]);
			stage_u.set_fault(1'b0);
			wait_cyc(8);
			rd(tcd_pkg::IDX_FAULT_CTRL, 32'({ftab[i][0], 2'b00}), 32'h0000_0004);
			clear_fault(ftab[i][10:3]);
		end
		// three high samples must not pass the filter
		wr(tcd_pkg::IDX_FAULT_CTRL, 32'h0000_00f0);
		stage_u.set_fault(1'b1);
		wait_cyc(2);
		stage_u.set_fault(1'b0);
		wait_cyc(10);
		cmp_bit("irq short pulse", 1'b0, irq);
		stage_u.set_fault(1'b1);
		wait_cyc(5);
		cmp_bit("irq filter delay", 1'b0, irq);
		wait_cyc(10);
		cmp_bit("irq filtered", 1'b1, irq);
		clear_fault(8'hf0);
		stage_u.set_fault(1'b0);
		wait_cyc(10);
		$display("fault test done");
		stop_test();
	end
endmodule // tb
